// ### core/rcfl_channel.sv
/*
 * One reference monitor channel: coarse frequency check over a gate window and a
 * single-cycle period check on every rising edge after the first.
 * Assumes a synchronised reference level and a one-cycle gate tick from the bank.
 */
`timescale 1ns/1ps
`default_nettype none

module rcfl_channel
    import rcfl_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    rcfl_mon_if.chan   mon
);

    typedef struct packed {
        logic             prev_level;
        logic             seen_edge;
        logic [CNT_W-1:0] edge_count;
        logic [CNT_W-1:0] period_count;
        logic             coarse_fail;
        logic             single_fail;
    } rcfl_chan_s;

    rcfl_chan_s state_reg;
    rcfl_chan_s state_next;

    logic rise;

    always_comb begin
        state_next            = state_reg;
        rise                  = mon.ref_level & ~state_reg.prev_level;
        state_next.prev_level = mon.ref_level;
        if (state_reg.period_count != '1) begin
            state_next.period_count = state_reg.period_count + 16'h0001;
        end
        if (rise) begin
            // Period times nominal count is compared to the package GATE_CYCLES, not the bank's GATE_LEN, avoiding a divider.
            if (state_reg.seen_edge) begin
                state_next.single_fail = out_of_tol(48'(state_reg.period_count) * 48'(mon.nominal_count),
                                                    48'(GATE_CYCLES),
                                                    mon.single_cycle_limit_code); // RULE_06 RULE_07
            end
            state_next.seen_edge    = 1'b1;
            state_next.period_count = 16'h0001;
            if (state_reg.edge_count != '1) begin
                state_next.edge_count = state_reg.edge_count + 16'h0001;
            end
        end
        if (mon.gate_tick) begin
            // Fail is raised and cleared by each window's verdict alone.
            state_next.coarse_fail = out_of_tol(48'(state_reg.edge_count), 48'(mon.nominal_count),
                                                mon.coarse_limit_code); // RULE_01 RULE_02 RULE_09
            state_next.edge_count  = rise ? 16'h0001 : 16'h0000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mon.coarse_fail = state_reg.coarse_fail;
    assign mon.single_fail = state_reg.single_fail;

endmodule

`default_nettype wire

// ### core/rcfl_mon_if.sv
/*
 * Carrier between the register bank and one reference monitor channel.
 * Assumes the reference level is already synchronised to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface rcfl_mon_if;
    import rcfl_pkg::*;
    logic                 ref_level;
    logic                 gate_tick;
    logic [CODE_W-1:0]    coarse_limit_code;
    logic [CODE_W-1:0]    single_cycle_limit_code;
    logic [CNT_W-1:0]     nominal_count;
    logic                 coarse_fail;
    logic                 single_fail;

    modport bank (output ref_level, gate_tick, coarse_limit_code, single_cycle_limit_code,
                  nominal_count, input coarse_fail, single_fail);
    modport chan (input ref_level, gate_tick, coarse_limit_code, single_cycle_limit_code,
                  nominal_count, output coarse_fail, single_fail);
endinterface

`default_nettype wire

// ### core/rcfl_pkg.sv
/*
 * Shared constants, field layout and tolerance arithmetic for the reference monitor limit block.
 * Assumes a single 40 MHz system clock and the documented 9-bit register address space.
 */
package rcfl_pkg;

    localparam int             NUM_REFS      = 11;
    localparam int             ADDR_W        = 9;
    localparam int             DATA_W        = 8;
    localparam int             CNT_W         = 16;
    localparam int             CODE_W        = 3;

    // One limit register per reference, references 0 to 10.
    localparam logic [NUM_REFS-1:0][ADDR_W-1:0] REF_LIMITS_ADDR = {
        9'h05a, 9'h059, 9'h058, 9'h057, 9'h056, 9'h055,
        9'h054, 9'h053, 9'h052, 9'h051, 9'h050
    };
    localparam logic [ADDR_W-1:0] PRECISE_LIMITS_ADDR = 9'h060;

    localparam logic [DATA_W-1:0] LIMITS_RESET  = 8'h55;
    localparam logic [DATA_W-1:0] PRECISE_RESET = 8'h33;

    localparam int             COARSE_LSB    = 0;
    localparam int             SINGLE_LSB    = 4;
    localparam logic [DATA_W-1:0] CODE_MASK  = 8'h77;

    // Coarse gate window.
    localparam int             CLK_FREQ_MHZ  = 40;
    localparam int             GATE_TIME_US  = 1000;
    localparam int             GATE_CYCLES   = GATE_TIME_US * CLK_FREQ_MHZ;

    // Sampling rate of the single-cycle monitor in the full device.
    localparam int             SCM_SAMPLE_MHZ  = 800;
    localparam int             SCM_GRAIN_PS    = 1000000 / SCM_SAMPLE_MHZ;

    localparam logic [47:0]    PERMILLE_SCALE  = 48'h0003e8;

    // Tolerance in tenths of a percent for a 3-bit limit code.
    function automatic logic [47:0] tol_permille(input logic [CODE_W-1:0] code);
        unique case (code)
            3'h0: tol_permille = 48'h000001;
            3'h1: tol_permille = 48'h000005;
            3'h2: tol_permille = 48'h00000a;
            3'h3: tol_permille = 48'h000014;
            3'h4: tol_permille = 48'h000032;
            3'h5: tol_permille = 48'h000064;
            3'h6: tol_permille = 48'h0000c8;
            3'h7: tol_permille = 48'h0001f4;
        endcase
    endfunction

    // True when meas differs from nom by more than the selected tolerance.
    function automatic logic out_of_tol(input logic [47:0] meas, input logic [47:0] nom,
                                        input logic [CODE_W-1:0] code);
        logic [47:0] dev;
        dev        = (meas > nom) ? (meas - nom) : (nom - meas);
        out_of_tol = (dev * PERMILLE_SCALE) > (nom * tol_permille(code));
    endfunction

endpackage

// ### core/rcfl_top.sv
/*
 * Per-reference monitor limit registers and the eleven reference monitors they steer.
 * Assumes a simple register port from the serial configuration engine and reference
 * clocks arriving asynchronously on pins.
 */
// How it works
// (RULE_01) A reference's coarse failure flag rises while it breaks the tolerance picked by its coarse code.
// (RULE_02) Coarse codes 0 to 7 pick 0.1, 0.5, 1, 2, 5, 10, 20 and 50 percent of the nominal frequency.
// (RULE_03) Software should give coarse and single-cycle codes the same value for references below 16 kHz.
// (RULE_04) Each of references 0 to 10 keeps its coarse code in bits 2:0 of its own limit register.
// (RULE_05) Each reference keeps its single-cycle code in bits 6:4 of that same register.
// (RULE_06) The single-cycle flag rises when one reference period breaks the tolerance its code picks.
// (RULE_07) Period granularity bounds how tight a limit can be used, so tight limits suit slow references.
// (RULE_08) Software should mask the single-cycle flag for references above 400 MHz.
// (RULE_09) The coarse check compares measured to nominal frequency and clears once back in tolerance.
`timescale 1ns/1ps
`default_nettype none

module rcfl_top
    import rcfl_pkg::*;
#(
    parameter int GATE_LEN = GATE_CYCLES
)
(
    input  wire logic                             CLK,
    input  wire logic                             RST,
    input  wire logic [ADDR_W-1:0]                REG_ADDR,
    input  wire logic                             REG_WR,
    input  wire logic [DATA_W-1:0]                REG_WDATA,
    input  wire logic                             REG_RD,
    output logic      [DATA_W-1:0]                REG_RDATA,
    input  wire logic [NUM_REFS-1:0]              REF_CLK,
    input  wire logic [NUM_REFS-1:0][CNT_W-1:0]   NOMINAL_COUNT,
    output logic      [NUM_REFS-1:0]              COARSE_FAIL,
    output logic      [NUM_REFS-1:0]              SINGLE_FAIL
);

    typedef struct packed {
        logic [NUM_REFS-1:0][DATA_W-1:0] limits;
        logic [DATA_W-1:0]               precise;
        logic [NUM_REFS-1:0]             sync1;
        logic [NUM_REFS-1:0]             sync2;
        logic [31:0]                     gate_count;
        logic                            gate_tick;
        logic [DATA_W-1:0]               rdata;
        logic [NUM_REFS-1:0]             coarse_fail;
        logic [NUM_REFS-1:0]             single_fail;
    } rcfl_top_s;

    rcfl_top_s state_reg;
    rcfl_top_s state_next;

    logic [NUM_REFS-1:0] chan_coarse;
    logic [NUM_REFS-1:0] chan_single;

    // Index of the limit register at an address, or NUM_REFS when none matches.
    function automatic logic [3:0] limit_index(input logic [ADDR_W-1:0] addr);
        limit_index = 4'(NUM_REFS);
        for (int i = 0; i < NUM_REFS; i++) begin
            if (addr == REF_LIMITS_ADDR[i]) begin
                limit_index = 4'(i);
            end
        end
    endfunction

    always_comb begin
        logic [3:0] idx;
        idx        = limit_index(REG_ADDR);
        state_next = state_reg;

        // Reference pins cross into the system clock through two flops.
        state_next.sync1 = REF_CLK;
        state_next.sync2 = state_reg.sync1;

        // Shared gate window for every coarse monitor.
        state_next.gate_tick = 1'b0;
        if (state_reg.gate_count >= 32'(GATE_LEN - 1)) begin
            state_next.gate_count = 32'h0000_0000;
            state_next.gate_tick  = 1'b1;
        end else begin
            state_next.gate_count = state_reg.gate_count + 32'h0000_0001;
        end

        // Reserved bits 7 and 3 are not stored and read back as zero.
        if (REG_WR) begin
            if (idx < 4'(NUM_REFS)) begin
                state_next.limits[idx] = REG_WDATA & CODE_MASK; // RULE_04 RULE_05
            end else if (REG_ADDR == PRECISE_LIMITS_ADDR) begin
                state_next.precise = REG_WDATA & CODE_MASK;
            end
        end
        if (REG_RD) begin
            if (idx < 4'(NUM_REFS)) begin
                state_next.rdata = state_reg.limits[idx];
            end else if (REG_ADDR == PRECISE_LIMITS_ADDR) begin
                state_next.rdata = state_reg.precise;
            end else begin
                state_next.rdata = 8'h00;
            end
        end

        state_next.coarse_fail = chan_coarse; // RULE_01
        state_next.single_fail = chan_single; // RULE_06
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg         <= '0;
            state_reg.limits  <= {NUM_REFS{LIMITS_RESET}};
            state_reg.precise <= PRECISE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    for (genvar g = 0; g < NUM_REFS; g++) begin : g_chan
        rcfl_mon_if mon ();

        assign mon.ref_level               = state_reg.sync2[g];
        assign mon.gate_tick               = state_reg.gate_tick;
        assign mon.coarse_limit_code       = state_reg.limits[g][COARSE_LSB +: CODE_W]; // RULE_04
        assign mon.single_cycle_limit_code = state_reg.limits[g][SINGLE_LSB +: CODE_W]; // RULE_05
        assign mon.nominal_count           = NOMINAL_COUNT[g];
        assign chan_coarse[g]              = mon.coarse_fail;
        assign chan_single[g]              = mon.single_fail;

        rcfl_channel u_chan (
            .clk (CLK),
            .rst (RST),
            .mon (mon.chan)
        );
    end

    assign REG_RDATA   = state_reg.rdata;
    assign COARSE_FAIL = state_reg.coarse_fail;
    assign SINGLE_FAIL = state_reg.single_fail;

endmodule

`default_nettype wire

// ### test/rcfl_properties.sv
/* Checker of the register port and monitor outputs of rcfl_top.
   Assumes a bind to rcfl_top and nothing but its ports. */
`timescale 1ns/1ps
`default_nettype none
module rcfl_properties
    import rcfl_pkg::*;
#(parameter int GATE_LEN = GATE_CYCLES)
(
    input wire logic                           CLK,
    input wire logic                           RST,
    input wire logic [ADDR_W-1:0]              REG_ADDR,
    input wire logic                           REG_WR,
    input wire logic [DATA_W-1:0]              REG_WDATA,
    input wire logic                           REG_RD,
    input wire logic [DATA_W-1:0]              REG_RDATA,
    input wire logic [NUM_REFS-1:0]            REF_CLK,
    input wire logic [NUM_REFS-1:0][CNT_W-1:0] NOMINAL_COUNT,
    input wire logic [NUM_REFS-1:0]            COARSE_FAIL,
    input wire logic [NUM_REFS-1:0]            SINGLE_FAIL
);
    logic        ref_q;
    logic [31:0] quiet_cnt;
    logic [3:0]  edge_age;
    // Two full windows plus pipeline slack, since a stop may fall mid-window.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ref_q     <= 1'b0;
            quiet_cnt <= '0;
            edge_age  <= 4'hf;
        end else begin
            ref_q     <= REF_CLK[0];
            quiet_cnt <= (REF_CLK[0] != ref_q) ? '0 : quiet_cnt + 32'h1;
            edge_age  <= (REF_CLK[0] && !ref_q) ? 4'h0 : ((edge_age == 4'hf) ? 4'hf : edge_age + 4'h1);
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_rd_reserved; REG_RD |=> (REG_RDATA & 8'h88) == 8'h00; endproperty
    a_rd_reserved: assert property (p_rd_reserved) else $error("Reserved bits read high.");
    property p_rd_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("Read data moved without a read.");
    property p_wr_rd;
        (REG_WR && REG_ADDR == 9'h050) ##1 (REG_RD && !REG_WR && REG_ADDR == 9'h050)
            |=> REG_RDATA == ($past(REG_WDATA, 2) & 8'h77);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("Limit codes not read back.");
    property p_unmapped; REG_RD && REG_ADDR == 9'h100 |=> REG_RDATA == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");
    property p_coarse_stand; $changed(COARSE_FAIL) |=> $stable(COARSE_FAIL) [*8]; endproperty
    a_coarse_stand: assert property (p_coarse_stand) else $error("Coarse verdict did not stand.");
    property p_coarse_lost; quiet_cnt > 2 * GATE_LEN + 8 && NOMINAL_COUNT[0] != '0 |-> COARSE_FAIL[0]; endproperty
    a_coarse_lost: assert property (p_coarse_lost) else $error("Lost reference not flagged.");
    property p_single_edge; $changed(SINGLE_FAIL[0]) |-> edge_age <= 4'h8; endproperty
    a_single_edge: assert property (p_single_edge) else $error("Single verdict off an edge.");
    c_coarse_rise: cover property ($rose(COARSE_FAIL[0]));
    c_coarse_fall: cover property ($fell(COARSE_FAIL[0]));
    c_single_rise: cover property ($rose(SINGLE_FAIL[0]));
endmodule
bind rcfl_top rcfl_properties #(.GATE_LEN(GATE_LEN)) u_rcfl_properties (.CLK(CLK), .RST(RST),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REF_CLK(REF_CLK), .NOMINAL_COUNT(NOMINAL_COUNT), .COARSE_FAIL(COARSE_FAIL), .SINGLE_FAIL(SINGLE_FAIL));
`default_nettype wire

// ### test/rcfl_ref_model.sv
/* Free-running reference clock sources, one per input.
   Assumes half periods in ns; zero stops a source at its level. */
`timescale 1ns/1ps
`default_nettype none
module rcfl_ref_model
    import rcfl_pkg::*;
(
    input  wire logic [NUM_REFS-1:0][7:0] half_ns,
    output var  logic [NUM_REFS-1:0]      ref_clk
);
    for (genvar g = 0; g < NUM_REFS; g++) begin : g_ref
        // Start offset of 3 + g ns keeps the edges off the system clock's phase.
        initial begin
            ref_clk[g] = 1'b0;
            #(3 + g);
            forever begin
                if (half_ns[g] == 8'h00) #1;
                else #(half_ns[g]) ref_clk[g] = ~ref_clk[g];
            end
        end
    end
endmodule
`default_nettype wire

// ### test/rcfl_top_test.sv
/* Self-checking bench of rcfl_top with a short coarse window.
   Assumes rcfl_ref_model drives the reference pins. */
`timescale 1ns/1ps
`default_nettype none
module rcfl_top_test
    import rcfl_pkg::*;
;
    localparam int GL = 400;
    logic CLK, RST, REG_WR, REG_RD;
    logic [ADDR_W-1:0] REG_ADDR;
    logic [DATA_W-1:0] REG_WDATA, REG_RDATA;
    logic [NUM_REFS-1:0] REF_CLK, COARSE_FAIL, SINGLE_FAIL;
    logic [NUM_REFS-1:0][CNT_W-1:0] NOMINAL_COUNT;
    logic [NUM_REFS-1:0][7:0] half;
    int fails, samples_checked;
    int tol[8] = '{1, 5, 10, 20, 50, 100, 200, 500};
    rcfl_top #(.GATE_LEN(GL)) u_rcfl_top (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
        .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REF_CLK(REF_CLK),
        .NOMINAL_COUNT(NOMINAL_COUNT), .COARSE_FAIL(COARSE_FAIL), .SINGLE_FAIL(SINGLE_FAIL));
    rcfl_ref_model u_rcfl_ref_model (.half_ns(half), .ref_clk(REF_CLK));
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobes stay up between back-to-back calls so no signal is set twice in one step; wait_cycles drops them.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        REG_ADDR = a; REG_WDATA = d; REG_RD = 1'b0; REG_WR = 1'b1;
        @(posedge CLK);
        #1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        REG_ADDR = a; REG_WR = 1'b0; REG_RD = 1'b1;
        @(posedge CLK);
        #1;
        check({3'h0, REG_RDATA}, {3'h0, e});
    endtask
    task automatic wait_cycles(input int n);
        REG_WR = 1'b0; REG_RD = 1'b0;
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic wr_all(input logic [2:0] c);
        for (int i = 0; i < NUM_REFS; i++) wr(REF_LIMITS_ADDR[i], {1'b0, c, 1'b0, c});
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    initial begin
        #(100000 * 25);
        fails++;
        wrap_up();
    end
    initial begin
        RST = 1'b1; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = '0; REG_WDATA = '0;
        for (int i = 0; i < NUM_REFS; i++) begin
            NOMINAL_COUNT[i] = 16'h0032;
            half[i] = 8'h7d;
        end
        repeat (10) @(posedge CLK);
        #1 RST = 1'b0;
        for (int i = 0; i < NUM_REFS; i++) rd(REF_LIMITS_ADDR[i], 8'h55);
        rd(PRECISE_LIMITS_ADDR, 8'h33);
        for (int i = 0; i < NUM_REFS; i++) begin
            wr(REF_LIMITS_ADDR[i], 8'(i * 19) ^ 8'h88);
            rd(REF_LIMITS_ADDR[i], (8'(i * 19) ^ 8'h88) & 8'h77);
        end
        wr(9'h100, 8'hff);
        rd(9'h100, 8'h00);
        rd(9'h05b, 8'h00);
        // Period of 10 cycles against 50 expected edges is exactly 20 percent off.
        for (int c = 7; c >= 0; c--) begin
            wr_all(3'(c));
            wait_cycles(3 * GL + 10);
            check(COARSE_FAIL, (10000 > 50 * tol[c]) ? 11'h7ff : 11'h000);
        end
        for (int i = 0; i < NUM_REFS; i++) half[i] = 8'h64;
        wait_cycles(3 * GL + 10);
        check(COARSE_FAIL, 11'h000);
        half[0] = 8'h00;
        wait_cycles(3 * GL + 10);
        check(COARSE_FAIL, 11'h001);
        NOMINAL_COUNT[0] = 16'h1388;
        half[0] = 8'h7d;
        // Period 10 with 5000 edges gives 50000 against 40000, 25 percent off.
        for (int c = 7; c >= 0; c--) begin
            wr(REF_LIMITS_ADDR[0], {1'b0, 3'(c), 4'h0});
            wait_cycles(60);
            check({10'h0, SINGLE_FAIL[0]}, {10'h0, 10000000 > 40000 * tol[c]});
        end
        half[0] = 8'h64;
        wait_cycles(60);
        check({10'h0, SINGLE_FAIL[0]}, 11'h000);
        // Period 8 against a nominal of 50 edges is far outside even the tightest code.
        check(SINGLE_FAIL, 11'h7fe);
        wrap_up();
    end
endmodule
`default_nettype wire
